/* pkc_cpu_model.sv */
/*
 * pkc_cpu_model: processor side of the translation unit, issuing fetch,
 * load, store and stack references one at a time.
 * assumes: pkc_top takes a request on an edge with acc_ready high and
 * answers in the cycle that follows.
 */
`timescale 1ns/1ps
`default_nettype none
module pkc_cpu_model (
  // clock
  input wire logic core_clk,
  // request
  output logic acc_valid,
  output pkc_pkg::pkc_acc_e acc_kind,
  output logic [63:0] acc_va,
  input wire logic acc_ready,
  // answer
  input wire logic rsp_valid
);
  import pkc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    acc_valid = 1'b0;
    acc_kind = PKC_A_FETCH;
    acc_va = 64'h0;
  end
  // holds the request until an edge sees acc_ready or 21 edges pass, then drops it
  task automatic access(input pkc_acc_e kind, input logic [63:0] va, output logic got);
    int n;
    n = 0;
    acc_kind = kind;
    acc_va = va;
    acc_valid = 1'b1;
    @(posedge core_clk);
    while (acc_ready !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    #1;
    acc_valid = 1'b0;
    // a released address does not keep its last value
    acc_va = ~va;
    got = rsp_valid;
  endtask : access
endmodule : pkc_cpu_model
`default_nettype wire

/* pkc_defs.svh */
/*
 * constants of the protection-key checking translation unit: address
 * layout, key register word fields, sizes and reset values.
 * assumes: included by bare name; holds definitions only.
 */
`ifndef PKC_DEFS_SVH
`define PKC_DEFS_SVH
// virtual address layout
`define PKC_VA_W 64
`define PKC_VRN_HI 63
`define PKC_VRN_LO 61
`define PKC_VPN_HI 60
`define PKC_VPN_LO 12
`define PKC_VPN_W 49
`define PKC_PPN_W 38
`define PKC_RID_W 24
`define PKC_NRR 8
// key register word fields
`define PKC_KR_W 64
`define PKC_KR_V 0
`define PKC_KR_WD 1
`define PKC_KR_RD 2
`define PKC_KR_XD 3
`define PKC_KR_KLO 8
`define PKC_KEY_W 24
`define PKC_KEY_W_MIN 18
// sizes
`define PKC_NKEY 16
`define PKC_NTR 8
`define PKC_TC_SETS 4
`define PKC_TC_WAYS 2
// reset values
`define PKC_KR_RST 64'h0
`define PKC_RR_RST 24'h0
`endif

/* pkc_key_match.sv */
/*
 * pkc_key_match: compares one translation key against the key cache.
 * assumes: combinational; caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pkc_defs.svh"
module pkc_key_match #(
  parameter int NKEY = `PKC_NKEY
) (
  // key cache contents
  input wire pkc_pkg::pkc_key_reg_t [NKEY-1:0] keys,
  // key tagged to the translation
  input wire logic [`PKC_KEY_W-1:0] tag,
  // result
  output logic hit,
  output pkc_pkg::pkc_key_reg_t match
);
  import pkc_pkg::*;

  logic [NKEY-1:0] eq;

  for (genvar i = 0; i < NKEY; i++) begin : g_cmp
    assign eq[i] = keys[i].v && (keys[i].key == tag);
  end

  // duplicates merge their disable bits, the strictest wins
  always_comb begin
    match = '0;
    for (int i = 0; i < NKEY; i++) begin
      if (eq[i]) begin
        match = match | keys[i];
      end
    end
  end

  assign hit = |eq;
endmodule : pkc_key_match
`default_nettype wire

/* pkc_pkg.sv */
/*
 * types shared by the protection-key checking translation unit.
 * assumes: pkc_defs.svh is on the include path.
 */
`include "pkc_defs.svh"
package pkc_pkg;
  typedef struct packed {
    logic r;
    logic w;
    logic x;
  } pkc_ar_t;

  typedef struct packed {
    logic v;
    logic [`PKC_RID_W-1:0] rid;
    logic [`PKC_VPN_W-1:0] virtual_page_number;
    logic [`PKC_PPN_W-1:0] ppn;
    logic [`PKC_KEY_W-1:0] key;
    pkc_ar_t ar;
  } pkc_tlb_ent_t;

  typedef struct packed {
    logic [`PKC_KEY_W-1:0] key;
    logic exec_block;
    logic read_block;
    logic write_block;
    logic v;
  } pkc_key_reg_t;

  typedef enum logic [2:0] {
    PKC_A_FETCH, PKC_A_LOAD, PKC_A_STORE, PKC_A_RSE_LOAD, PKC_A_RSE_STORE
  } pkc_acc_e;
  typedef enum logic [2:0] {
    PKC_F_NONE, PKC_F_TLB_MISS, PKC_F_RIGHTS, PKC_F_KEY_MISS, PKC_F_KEY_PERM
  } pkc_fault_e;
  typedef enum logic [1:0] {PKC_I_TR_I, PKC_I_TR_D, PKC_I_TC_I, PKC_I_TC_D} pkc_ins_e;
  typedef enum logic [1:0] {PKC_P_TR_I, PKC_P_TR_D, PKC_P_TC} pkc_pur_e;
endpackage : pkc_pkg

/* pkc_tlb_array.sv */
/*
 * pkc_tlb_array: one translation buffer (pinned slots plus a
 * set-associative cache) with lookup, insert and purge.
 * assumes: at most one insert and one purge per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pkc_defs.svh"
module pkc_tlb_array #(
  parameter int NTR = `PKC_NTR,
  parameter int SETS = `PKC_TC_SETS,
  parameter int WAYS = `PKC_TC_WAYS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // insert
  input wire logic ins_tr,
  input wire logic ins_tc,
  input wire logic [$clog2(NTR)-1:0] ins_slot,
  input wire pkc_pkg::pkc_tlb_ent_t ins_ent,
  // purge
  input wire logic pur_tr,
  input wire logic pur_tc,
  input wire logic [`PKC_RID_W-1:0] pur_rid,
  input wire logic [`PKC_VPN_W-1:0] pur_vpn,
  // lookup
  input wire logic [`PKC_RID_W-1:0] lk_rid,
  input wire logic [`PKC_VPN_W-1:0] lk_vpn,
  output logic lk_hit,
  output pkc_pkg::pkc_tlb_ent_t lk_ent
);
  import pkc_pkg::*;

  localparam int SW = $clog2(SETS);
  localparam int WW = $clog2(WAYS);

  if (NTR < `PKC_NTR || SETS < 2 || WAYS < 2 || (1 << SW) != SETS ||
      (1 << WW) != WAYS || (1 << $clog2(NTR)) != NTR) begin : g_bad
    $error("pkc_tlb_array: unsupported sizes");
  end

  typedef struct packed {
    pkc_tlb_ent_t [NTR-1:0] tr;
    pkc_tlb_ent_t [SETS*WAYS-1:0] tc;
    logic [WW-1:0] vict;
  } pkc_tlb_st_t;

  pkc_tlb_st_t st_q;
  pkc_tlb_st_t st_d;

  // region id and page must both match
  function automatic logic same(input pkc_tlb_ent_t e, input logic [`PKC_RID_W-1:0] rid,
                                input logic [`PKC_VPN_W-1:0] virtual_page_number);
    same = e.v && (e.rid == rid) && (e.virtual_page_number == virtual_page_number);
  endfunction : same

  always_comb begin
    lk_hit = 1'b0;
    lk_ent = '0;
    for (int i = 0; i < NTR; i++) begin
      if (same(st_q.tr[i], lk_rid, lk_vpn)) begin
        lk_hit = 1'b1;
        lk_ent = st_q.tr[i];
      end
    end
    for (int w = 0; w < WAYS; w++) begin
      if (same(st_q.tc[{lk_vpn[SW-1:0], WW'(w)}], lk_rid, lk_vpn)) begin
        lk_hit = 1'b1;
        lk_ent = st_q.tc[{lk_vpn[SW-1:0], WW'(w)}];
      end
    end
  end

  always_comb begin
    st_d = st_q;
    for (int i = 0; i < SETS*WAYS; i++) begin
      // an insert drops overlapping cache entries first
      if ((ins_tr || ins_tc) && same(st_q.tc[i], ins_ent.rid, ins_ent.virtual_page_number)) begin
        st_d.tc[i].v = 1'b0;
      end
      if (pur_tc && same(st_q.tc[i], pur_rid, pur_vpn)) begin
        st_d.tc[i].v = 1'b0;
      end
    end
    for (int i = 0; i < NTR; i++) begin
      if (pur_tr && same(st_q.tr[i], pur_rid, pur_vpn)) begin
        st_d.tr[i].v = 1'b0;
      end
    end
    if (ins_tr) begin
      st_d.tr[ins_slot] = ins_ent;
    end
    if (ins_tc) begin
      st_d.tc[{ins_ent.virtual_page_number[SW-1:0], st_q.vict}] = ins_ent;
      st_d.vict = st_q.vict + WW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : pkc_tlb_array
`default_nettype wire

/* pkc_top.sv */
/*
 * pkc_top: address translation with protection-key checking. holds the
 * key register cache, region registers and split translation buffers.
 * assumes: requests and software writes arrive synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pkc_defs.svh"
module pkc_top #(
  parameter int NKEY = `PKC_NKEY,
  parameter int KEY_W = `PKC_KEY_W,
  parameter int NTR = `PKC_NTR,
  parameter int TC_SETS = `PKC_TC_SETS,
  parameter int TC_WAYS = `PKC_TC_WAYS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // processor status
  input wire logic key_check_enable,
  // key register write and read
  input wire logic kr_we,
  input wire logic [$clog2(NKEY)-1:0] kr_idx,
  input wire logic [`PKC_KR_W-1:0] kr_wdata,
  input wire logic [$clog2(NKEY)-1:0] kr_ridx,
  output logic [`PKC_KR_W-1:0] kr_rdata,
  // region register write
  input wire logic rr_we,
  input wire logic [2:0] rr_idx,
  input wire logic [`PKC_RID_W-1:0] rr_wdata,
  // translation insert
  input wire logic ins_valid,
  input wire pkc_pkg::pkc_ins_e ins_kind,
  input wire logic [$clog2(NTR)-1:0] ins_slot,
  input wire logic [`PKC_VA_W-1:0] ins_va,
  input wire logic [`PKC_PPN_W-1:0] ins_ppn,
  input wire logic [`PKC_KEY_W-1:0] ins_key,
  input wire pkc_pkg::pkc_ar_t ins_ar,
  // translation purge
  input wire logic pur_valid,
  input wire pkc_pkg::pkc_pur_e pur_kind,
  input wire logic [`PKC_VA_W-1:0] pur_va,
  // data buffer key read
  input wire logic tak_valid,
  input wire logic [`PKC_VA_W-1:0] tak_va,
  output logic tak_done,
  output logic tak_hit,
  output logic [`PKC_KEY_W-1:0] tak_key,
  // access request
  input wire logic acc_valid,
  output logic acc_ready,
  input wire pkc_pkg::pkc_acc_e acc_kind,
  input wire logic [`PKC_VA_W-1:0] acc_va,
  // access answer
  output logic rsp_valid,
  output pkc_pkg::pkc_fault_e rsp_fault,
  output logic rsp_commit,
  output logic [`PKC_PPN_W+`PKC_VPN_LO-1:0] rsp_pa
);
  import pkc_pkg::*;

  if (NKEY < `PKC_NKEY || (1 << $clog2(NKEY)) != NKEY ||
      KEY_W < `PKC_KEY_W_MIN || KEY_W > `PKC_KEY_W ||
      NTR < `PKC_NTR || TC_SETS * TC_WAYS < 1) begin : g_bad
    $error("pkc_top: unsupported parameters");
  end

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    pkc_key_reg_t [NKEY-1:0] kr;
    logic [`PKC_NRR-1:0][`PKC_RID_W-1:0] rr;
    logic [`PKC_KR_W-1:0] kr_rdata;
    logic tak_done;
    logic tak_hit;
    logic [`PKC_KEY_W-1:0] tak_key;
    logic rsp_valid;
    pkc_fault_e rsp_fault;
    logic rsp_commit;
    logic [`PKC_PPN_W+`PKC_VPN_LO-1:0] rsp_pa;
  } pkc_top_st_t;

  pkc_top_st_t st_q;
  pkc_top_st_t st_d;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // unimplemented high key bits read and compare as zero
  function automatic logic [`PKC_KEY_W-1:0] key_mask(input logic [`PKC_KEY_W-1:0] k);
    key_mask = k & ((`PKC_KEY_W'(1) << KEY_W) - `PKC_KEY_W'(1));
  endfunction : key_mask

  function automatic pkc_key_reg_t kr_unpack(input logic [`PKC_KR_W-1:0] w);
    kr_unpack.v = w[`PKC_KR_V];
    kr_unpack.write_block = w[`PKC_KR_WD];
    kr_unpack.read_block = w[`PKC_KR_RD];
    kr_unpack.exec_block = w[`PKC_KR_XD];
    kr_unpack.key = key_mask(w[`PKC_KR_KLO +: `PKC_KEY_W]);
  endfunction : kr_unpack

  function automatic logic [`PKC_KR_W-1:0] kr_pack(input pkc_key_reg_t k);
    kr_pack = '0;
    kr_pack[`PKC_KR_V] = k.v;
    kr_pack[`PKC_KR_WD] = k.write_block;
    kr_pack[`PKC_KR_RD] = k.read_block;
    kr_pack[`PKC_KR_XD] = k.exec_block;
    kr_pack[`PKC_KR_KLO +: `PKC_KEY_W] = k.key;
  endfunction : kr_pack

  // region bits only choose a register, they never reach the buffers
  function automatic logic [`PKC_RID_W-1:0] rid_of(input logic [`PKC_VA_W-1:0] va);
    rid_of = st_q.rr[va[`PKC_VRN_HI:`PKC_VRN_LO]];
  endfunction : rid_of

  function automatic logic [`PKC_VPN_W-1:0] vpn_of(input logic [`PKC_VA_W-1:0] va);
    vpn_of = va[`PKC_VPN_HI:`PKC_VPN_LO];
  endfunction : vpn_of

  ////////////////////////////////////////////////////////////////////////
  // insert and purge decode

  pkc_tlb_ent_t ins_ent;
  logic ins_tr_i;
  logic ins_tr_d;
  logic ins_tc_i;
  logic ins_tc_d;
  logic pur_tr_i;
  logic pur_tr_d;
  logic pur_tc_i;
  logic pur_tc_d;

  always_comb begin
    ins_ent.v = 1'b1;
    ins_ent.rid = rid_of(ins_va);
    ins_ent.virtual_page_number = vpn_of(ins_va);
    ins_ent.ppn = ins_ppn;
    ins_ent.key = key_mask(ins_key);
    ins_ent.ar = ins_ar;
  end

  assign ins_tr_i = ins_valid && (ins_kind == PKC_I_TR_I);
  assign ins_tr_d = ins_valid && (ins_kind == PKC_I_TR_D);
  assign ins_tc_i = ins_valid && (ins_kind == PKC_I_TC_I);
  assign ins_tc_d = ins_valid && (ins_kind == PKC_I_TC_D);
  // slot purges pick one side; cache purges hit both sides
  assign pur_tr_i = pur_valid && (pur_kind == PKC_P_TR_I);
  assign pur_tr_d = pur_valid && (pur_kind == PKC_P_TR_D);
  assign pur_tc_i = pur_valid && (pur_kind != PKC_P_TR_D);
  assign pur_tc_d = pur_valid && (pur_kind != PKC_P_TR_I);

  ////////////////////////////////////////////////////////////////////////
  // translation buffers

  logic acc_fire;
  logic is_fetch;
  logic [`PKC_VA_W-1:0] d_va;
  logic i_hit;
  logic d_hit;
  logic t_hit;
  pkc_tlb_ent_t i_ent;
  pkc_tlb_ent_t d_ent;
  pkc_tlb_ent_t t_ent;

  // the key read shares the data lookup and holds accesses off
  assign acc_ready = !tak_valid;
  assign acc_fire = acc_valid && acc_ready;
  assign is_fetch = (acc_kind == PKC_A_FETCH);
  assign d_va = tak_valid ? tak_va : acc_va;

  // region ids recomputed whenever a region register changes too
  logic [`PKC_RID_W-1:0] pur_rid;
  logic [`PKC_RID_W-1:0] i_rid;
  logic [`PKC_RID_W-1:0] d_rid;

  always_comb begin
    pur_rid = rid_of(pur_va);
    i_rid = rid_of(acc_va);
    d_rid = rid_of(d_va);
  end

  pkc_tlb_array #(.NTR(NTR), .SETS(TC_SETS), .WAYS(TC_WAYS)) u_itlb (
    .core_clk(core_clk),
    .rstn(rstn),
    .ins_tr(ins_tr_i),
    .ins_tc(ins_tc_i),
    .ins_slot(ins_slot),
    .ins_ent(ins_ent),
    .pur_tr(pur_tr_i),
    .pur_tc(pur_tc_i),
    .pur_rid(pur_rid),
    .pur_vpn(vpn_of(pur_va)),
    .lk_rid(i_rid),
    .lk_vpn(vpn_of(acc_va)),
    .lk_hit(i_hit),
    .lk_ent(i_ent)
  );

  pkc_tlb_array #(.NTR(NTR), .SETS(TC_SETS), .WAYS(TC_WAYS)) u_dtlb (
    .core_clk(core_clk),
    .rstn(rstn),
    .ins_tr(ins_tr_d),
    .ins_tc(ins_tc_d),
    .ins_slot(ins_slot),
    .ins_ent(ins_ent),
    .pur_tr(pur_tr_d),
    .pur_tc(pur_tc_d),
    .pur_rid(pur_rid),
    .pur_vpn(vpn_of(pur_va)),
    .lk_rid(d_rid),
    .lk_vpn(vpn_of(d_va)),
    .lk_hit(d_hit),
    .lk_ent(d_ent)
  );

  // fetches use the instruction side, loads, stores and stack traffic the data side
  assign t_hit = is_fetch ? i_hit : d_hit;
  assign t_ent = is_fetch ? i_ent : d_ent;

  ////////////////////////////////////////////////////////////////////////
  // key check

  logic km_hit;
  pkc_key_reg_t km;
  logic want_r;
  logic want_w;
  logic want_x;
  logic key_deny;
  logic ar_deny;
  pkc_fault_e fault;

  pkc_key_match #(.NKEY(NKEY)) u_keys (
    .keys(st_q.kr),
    .tag(t_ent.key),
    .hit(km_hit),
    .match(km)
  );

  assign want_x = is_fetch;
  assign want_r = (acc_kind == PKC_A_LOAD) || (acc_kind == PKC_A_RSE_LOAD);
  assign want_w = (acc_kind == PKC_A_STORE) || (acc_kind == PKC_A_RSE_STORE);
  assign key_deny = (want_w && km.write_block) ||
                    (want_r && km.read_block) ||
                    (want_x && km.exec_block);
  assign ar_deny = (want_w && !t_ent.ar.w) || (want_r && !t_ent.ar.r) || (want_x && !t_ent.ar.x);

  always_comb begin
    fault = PKC_F_NONE;
    if (!t_hit) begin
      fault = PKC_F_TLB_MISS;
    end else if (key_check_enable && !km_hit) begin
      fault = PKC_F_KEY_MISS;
    end else if (key_check_enable && key_deny) begin
      fault = PKC_F_KEY_PERM;
    end else if (ar_deny) begin
      fault = PKC_F_RIGHTS;
    end
    if (!acc_fire) begin
      fault = PKC_F_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state and registers

  always_comb begin
    st_d = st_q;
    if (kr_we) begin
      st_d.kr[kr_idx] = kr_unpack(kr_wdata);
    end
    if (rr_we) begin
      st_d.rr[rr_idx] = rr_wdata;
    end
    st_d.kr_rdata = kr_pack(st_q.kr[kr_ridx]);
    st_d.tak_done = tak_valid;
    st_d.tak_hit = tak_valid && d_hit;
    st_d.tak_key = (tak_valid && d_hit) ? d_ent.key : '0;
    st_d.rsp_valid = acc_fire;
    st_d.rsp_fault = fault;
    // only a clean access may commit its memory effect
    st_d.rsp_commit = acc_fire && (fault == PKC_F_NONE);
    st_d.rsp_pa = st_d.rsp_commit ? {t_ent.ppn, acc_va[`PKC_VPN_LO-1:0]} : '0;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      for (int i = 0; i < NKEY; i++) begin
        st_q.kr[i] <= kr_unpack(`PKC_KR_RST);
      end
      for (int i = 0; i < `PKC_NRR; i++) begin
        st_q.rr[i] <= `PKC_RR_RST;
      end
    end else begin
      st_q <= st_d;
    end
  end

  assign kr_rdata = st_q.kr_rdata;
  assign tak_done = st_q.tak_done;
  assign tak_hit = st_q.tak_hit;
  assign tak_key = st_q.tak_key;
  assign rsp_valid = st_q.rsp_valid;
  assign rsp_fault = st_q.rsp_fault;
  assign rsp_commit = st_q.rsp_commit;
  assign rsp_pa = st_q.rsp_pa;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_keyed;
    acc_fire && key_check_enable && t_hit && km_hit;
  endsequence

  sequence s_perm_fault;
    rsp_valid && (rsp_fault == PKC_F_KEY_PERM) && !rsp_commit;
  endsequence

  chk_acc_answer:
  assert property (acc_fire |=> rsp_valid ##1 !rsp_valid || $past(acc_fire))
    else $error("access not answered in one cycle");

  chk_check_off:
  assert property (acc_fire && !key_check_enable |=>
                   rsp_fault != PKC_F_KEY_MISS && rsp_fault != PKC_F_KEY_PERM)
    else $error("key fault while checking disabled");

  chk_kr_store:
  assert property (kr_we ##1 (kr_ridx == $past(kr_idx)) && !kr_we |=>
                   kr_rdata[`PKC_KR_V] == $past(kr_wdata[`PKC_KR_V], 2))
    else $error("key register write not readable");

  chk_key_miss:
  assert property (acc_fire && key_check_enable && t_hit && !km_hit |=>
                   rsp_fault == PKC_F_KEY_MISS && !rsp_commit)
    else $error("missing key not faulted");

  chk_wr_block:
  assert property (s_keyed ##0 (want_w && km.write_block) |=> s_perm_fault)
    else $error("write not refused by key");

  chk_rd_block:
  assert property (s_keyed ##0 (want_r && km.read_block) |=> s_perm_fault)
    else $error("read not refused by key");

  chk_ex_block:
  assert property (s_keyed ##0 (want_x && km.exec_block) |=> s_perm_fault)
    else $error("fetch not refused by key");

  chk_key_pass:
  assert property (s_keyed ##0 (!key_deny && !ar_deny) |=>
                   rsp_commit && rsp_pa[`PKC_VPN_LO-1:0] == $past(acc_va[`PKC_VPN_LO-1:0]))
    else $error("permitted access not completed");

  chk_key_read:
  assert property (tak_valid |=> tak_done && tak_hit == $past(d_hit) && !rsp_valid)
    else $error("key read answer wrong");

  chk_tlb_miss:
  assert property (acc_fire && !t_hit |=> rsp_fault == PKC_F_TLB_MISS)
    else $error("translation miss not reported");

  chk_no_commit:
  assert property (rsp_valid && rsp_fault != PKC_F_NONE |-> !rsp_commit && rsp_pa == '0)
    else $error("faulting access committed");
endmodule : pkc_top
`default_nettype wire

/* testbench.sv */
/*
 * testbench: self-checking bench for pkc_top with the processor model.
 * assumes: pkc_pkg and pkc_defs.svh compiled first; default parameters.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pkc_pkg::*;
  logic core_clk, rstn, key_check_enable, kr_we, rr_we, ins_valid, pur_valid, tak_valid;
  logic [3:0] kr_idx, kr_ridx;
  logic [63:0] kr_wdata, kr_rdata, ins_va, pur_va, tak_va, acc_va;
  logic [2:0] rr_idx, ins_slot;
  logic [23:0] rr_wdata, ins_key, tak_key;
  pkc_ins_e ins_kind;
  logic [37:0] ins_ppn;
  pkc_ar_t ins_ar;
  pkc_pur_e pur_kind;
  pkc_acc_e acc_kind;
  pkc_fault_e rsp_fault;
  logic tak_done, tak_hit, acc_valid, acc_ready, rsp_valid, rsp_commit;
  logic [49:0] rsp_pa;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  pkc_top u_pkc_top (.core_clk(core_clk), .rstn(rstn), .key_check_enable(key_check_enable),
    .kr_we(kr_we), .kr_idx(kr_idx), .kr_wdata(kr_wdata), .kr_ridx(kr_ridx), .kr_rdata(kr_rdata),
    .rr_we(rr_we), .rr_idx(rr_idx), .rr_wdata(rr_wdata), .ins_valid(ins_valid), .ins_kind(ins_kind),
    .ins_slot(ins_slot), .ins_va(ins_va), .ins_ppn(ins_ppn), .ins_key(ins_key), .ins_ar(ins_ar),
    .pur_valid(pur_valid), .pur_kind(pur_kind), .pur_va(pur_va), .tak_valid(tak_valid),
    .tak_va(tak_va), .tak_done(tak_done), .tak_hit(tak_hit), .tak_key(tak_key),
    .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_kind(acc_kind), .acc_va(acc_va),
    .rsp_valid(rsp_valid), .rsp_fault(rsp_fault), .rsp_commit(rsp_commit), .rsp_pa(rsp_pa));
  pkc_cpu_model u_pkc_cpu_model (.core_clk(core_clk), .acc_valid(acc_valid), .acc_kind(acc_kind),
    .acc_va(acc_va), .acc_ready(acc_ready), .rsp_valid(rsp_valid));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_f(input pkc_fault_e g, input pkc_fault_e e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_f
  function automatic logic [63:0] va(input logic [2:0] r, input logic [48:0] p);
    return {r, p, 12'h5a4};
  endfunction : va
  function automatic logic [63:0] kw(input logic [23:0] k, input logic [3:0] xrwv);
    return {32'h0, k, 4'h0, xrwv};
  endfunction : kw
  task automatic wk(input logic [3:0] i, input logic [63:0] w);
    kr_we = 1'b1;
    kr_idx = i;
    kr_wdata = w;
    kr_ridx = i;
    tick();
    kr_we = 1'b0;
  endtask : wk
  task automatic wr(input logic [2:0] i, input logic [23:0] rid);
    rr_we = 1'b1;
    rr_idx = i;
    rr_wdata = rid;
    tick();
    rr_we = 1'b0;
    tick();
  endtask : wr
  task automatic ins(input pkc_ins_e k, input logic [2:0] s, input logic [63:0] a,
                     input logic [37:0] p, input logic [23:0] key, input pkc_ar_t ar = 3'b111);
    ins_valid = 1'b1;
    ins_kind = k;
    ins_slot = s;
    ins_va = a;
    ins_ppn = p;
    ins_key = key;
    ins_ar = ar;
    tick();
    ins_valid = 1'b0;
  endtask : ins
  task automatic pur(input pkc_pur_e k, input logic [63:0] a);
    pur_valid = 1'b1;
    pur_kind = k;
    pur_va = a;
    tick();
    pur_valid = 1'b0;
  endtask : pur
  // one access through the processor model, judged on every answer field
  task automatic acc(input pkc_acc_e k, input logic [63:0] a, input pkc_fault_e f, input logic [37:0] p);
    logic got;
    u_pkc_cpu_model.access(k, a, got);
    chk(got, 1'b1);
    chk_f(rsp_fault, f);
    chk(rsp_commit, f == PKC_F_NONE);
    chk(rsp_pa, (f == PKC_F_NONE) ? {p, a[11:0]} : 50'h0);
    tick();
  endtask : acc
  task automatic tk(input logic [63:0] a, input logic h, input logic [23:0] key);
    tak_valid = 1'b1;
    tak_va = a;
    #1;
    chk(acc_ready, 1'b0);
    tick();
    tak_valid = 1'b0;
    chk(tak_done, 1'b1);
    chk(tak_hit, h);
    chk(tak_key, key);
    tick();
  endtask : tk
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    kr_ridx = 4'hf;
    tick();
    chk(kr_rdata, 64'h0);
    chk(rsp_valid, 1'b0);
  endtask : t_reset
  task automatic t_xlate();
    wr(3'h1, 24'h5);
    wr(3'h2, 24'h5);
    wr(3'h3, 24'h9);
    ins(PKC_I_TR_D, 3'h2, va(3'h1, 49'h10), 38'h123, 24'h00000a);
    acc(PKC_A_LOAD, va(3'h1, 49'h10), PKC_F_NONE, 38'h123);
    acc(PKC_A_STORE, va(3'h2, 49'h10), PKC_F_NONE, 38'h123);
    acc(PKC_A_LOAD, va(3'h3, 49'h10), PKC_F_TLB_MISS, 38'h0);
  endtask : t_xlate
  task automatic t_keys();
    key_check_enable = 1'b1;
    acc(PKC_A_LOAD, va(3'h1, 49'h10), PKC_F_KEY_MISS, 38'h0);
    wk(4'h3, kw(24'h00000a, 4'b0011));
    tick();
    chk(kr_rdata, kw(24'h00000a, 4'b0011));
    acc(PKC_A_LOAD, va(3'h1, 49'h10), PKC_F_NONE, 38'h123);
    acc(PKC_A_STORE, va(3'h1, 49'h10), PKC_F_KEY_PERM, 38'h0);
    acc(PKC_A_RSE_STORE, va(3'h1, 49'h10), PKC_F_KEY_PERM, 38'h0);
    wk(4'h3, kw(24'h00000a, 4'b0101));
    acc(PKC_A_LOAD, va(3'h1, 49'h10), PKC_F_KEY_PERM, 38'h0);
    acc(PKC_A_RSE_LOAD, va(3'h1, 49'h10), PKC_F_KEY_PERM, 38'h0);
    acc(PKC_A_STORE, va(3'h1, 49'h10), PKC_F_NONE, 38'h123);
    wk(4'h3, kw(24'h00000a, 4'b0000));
    acc(PKC_A_LOAD, va(3'h1, 49'h10), PKC_F_KEY_MISS, 38'h0);
    wk(4'h3, kw(24'h00000a, 4'b0001));
    acc(PKC_A_STORE, va(3'h1, 49'h10), PKC_F_NONE, 38'h123);
  endtask : t_keys
  task automatic t_fetch();
    ins(PKC_I_TR_I, 3'h7, va(3'h1, 49'h20), 38'h77, 24'h00000b);
    wk(4'hf, kw(24'h00000b, 4'b1001));
    acc(PKC_A_FETCH, va(3'h1, 49'h20), PKC_F_KEY_PERM, 38'h0);
    wk(4'hf, kw(24'h00000b, 4'b0001));
    acc(PKC_A_FETCH, va(3'h1, 49'h20), PKC_F_NONE, 38'h77);
    tk(va(3'h1, 49'h20), 1'b0, 24'h0);
    tk(va(3'h1, 49'h10), 1'b1, 24'h00000a);
  endtask : t_fetch
  task automatic t_purge();
    pur(PKC_P_TR_D, va(3'h1, 49'h10));
    acc(PKC_A_LOAD, va(3'h1, 49'h10), PKC_F_TLB_MISS, 38'h0);
    acc(PKC_A_FETCH, va(3'h1, 49'h20), PKC_F_NONE, 38'h77);
    ins(PKC_I_TC_D, 3'h0, va(3'h1, 49'h30), 38'h301, 24'h00000a);
    acc(PKC_A_LOAD, va(3'h1, 49'h30), PKC_F_NONE, 38'h301);
    ins(PKC_I_TC_I, 3'h0, va(3'h1, 49'h31), 38'h311, 24'h00000b);
    acc(PKC_A_FETCH, va(3'h1, 49'h31), PKC_F_NONE, 38'h311);
    pur(PKC_P_TC, va(3'h1, 49'h30));
    acc(PKC_A_LOAD, va(3'h1, 49'h30), PKC_F_TLB_MISS, 38'h0);
    pur(PKC_P_TC, va(3'h1, 49'h31));
    acc(PKC_A_FETCH, va(3'h1, 49'h31), PKC_F_TLB_MISS, 38'h0);
    pur(PKC_P_TR_I, va(3'h1, 49'h20));
    acc(PKC_A_FETCH, va(3'h1, 49'h20), PKC_F_TLB_MISS, 38'h0);
  endtask : t_purge
  // page rights still apply under a permissive key; keys ignored when off
  task automatic t_rights();
    ins(PKC_I_TR_D, 3'h4, va(3'h1, 49'h40), 38'h44, 24'h00000a, 3'b100);
    acc(PKC_A_STORE, va(3'h1, 49'h40), PKC_F_RIGHTS, 38'h0);
    acc(PKC_A_LOAD, va(3'h1, 49'h40), PKC_F_NONE, 38'h44);
    wk(4'h3, kw(24'h00000a, 4'b0101));
    key_check_enable = 1'b0;
    acc(PKC_A_LOAD, va(3'h1, 49'h40), PKC_F_NONE, 38'h44);
  endtask : t_rights
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    {key_check_enable, kr_we, rr_we, ins_valid, pur_valid, tak_valid} = 6'h0;
    {kr_idx, kr_ridx, rr_idx, ins_slot, rr_wdata, ins_key} = 62'h0;
    {kr_wdata, ins_va, pur_va, tak_va, ins_ppn} = 294'h0;
    ins_kind = PKC_I_TR_I;
    ins_ar = 3'b000;
    pur_kind = PKC_P_TR_I;
    repeat (20) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_xlate();
    t_keys();
    t_fetch();
    t_purge();
    t_rights();
    final_report();
  end
endmodule : testbench
`default_nettype wire
